// file: dv/pvq_mem_model.sv
// Shared descriptor ring memory model answering the engine
`timescale 1ns/1ps
module pvq_mem_model (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Memory slave
    input  wire logic         mem_req,
    input  wire logic         mem_we,
    input  wire logic [63:0]  mem_addr,
    input  wire logic [127:0] mem_wdata,
    output logic              mem_ack,
    output logic      [127:0] mem_rdata
);
    logic [127:0] ram [8];
    logic [1:0]   lat_ff;
    logic [1:0]   cnt_ff;

    // Latency walks 0..3 so prompt and slow answers both occur
    always @(posedge clk_sys) begin
        mem_ack <= 1'b0;
        if (rst) begin
            cnt_ff    <= 2'h0;
            lat_ff    <= 2'h0;
            mem_rdata <= '0;
        end else if (mem_req && !mem_ack && cnt_ff == lat_ff) begin
            mem_ack <= 1'b1;
            cnt_ff  <= 2'h0;
            lat_ff  <= lat_ff + 2'h1;
            if (mem_we) ram[mem_addr[6:4]] <= mem_wdata;
            else mem_rdata <= ram[mem_addr[6:4]];
        end else begin
            cnt_ff    <= (mem_req && !mem_ack) ? cnt_ff + 2'h1 : 2'h0;
            // Stale data must not look valid outside an answer
            mem_rdata <= ~mem_rdata;
        end
    end

    // Ring starts zeroed, as the driver allocates it
    initial begin
        for (int i = 0; i < 8; i++) ram[i] = '0;
    end

    task put(input int slot, input logic [127:0] d);
        ram[slot] = d;
    endtask : put
endmodule : pvq_mem_model

// file: dv/pvq_ring_engine_checker.sv
// Port assertions for the packed ring engine
`timescale 1ns/1ps
module pvq_ring_engine_checker (
    // Clock and reset
    input wire logic         clk_sys,
    input wire logic         rst,
    // APB
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pready,
    // Memory
    input wire logic         mem_req,
    input wire logic         mem_we,
    input wire logic [63:0]  mem_addr,
    input wire logic [127:0] mem_wdata,
    input wire logic         mem_ack,
    input wire logic [127:0] mem_rdata,
    // Elements and notification
    input wire logic         elem_valid,
    input wire logic         elem_ready,
    input wire logic [63:0]  elem_addr,
    input wire logic [31:0]  elem_len,
    input wire logic         elem_wr,
    input wire logic         elem_last,
    input wire logic [15:0]  elem_id,
    input wire logic         used_notify
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence poll_hit;
        mem_req && !mem_we && mem_ack && (mem_rdata[127] != mem_rdata[119]);
    endsequence
    sequence last_hit;
        mem_req && !mem_we && mem_ack && (mem_rdata[127] != mem_rdata[119]) && !mem_rdata[112];
    endsequence

    apb_zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    apb_ready_phase_a: assert property (pready |-> psel && penable)
        else $error("pready outside access cycle");
    mem_hold_a: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
        && $stable(mem_wdata)) else $error("memory request changed before ack");
    mem_release_a: assert property (mem_ack |=> !mem_req)
        else $error("memory request not dropped after ack");
    used_flags_a: assert property (
        mem_req && mem_we |-> mem_wdata[127] == mem_wdata[119] && mem_wdata[63:0] == 64'h0)
        else $error("used descriptor flags or address wrong");
    used_notify_a: assert property (mem_req && mem_we && mem_ack |=> used_notify)
        else $error("no notification after used write");
    notify_cause_a: assert property (
        used_notify |-> $past(mem_req && mem_we && mem_ack)) else $error("stray notification");
    poll_skip_a: assert property (
        mem_ack && !mem_we && mem_rdata[127] == mem_rdata[119] |=> (!elem_valid) [*2])
        else $error("unavailable entry handed out");
    elem_fields_a: assert property (
        poll_hit ##2 $rose(elem_valid) |-> elem_addr == $past(mem_rdata[63:0], 2)
        && elem_len == $past(mem_rdata[95:64], 2) && elem_wr == $past(mem_rdata[113], 2))
        else $error("element fields differ from descriptor");
    elem_last_a: assert property (last_hit ##2 $rose(elem_valid) |-> elem_last)
        else $error("end of chain not marked");
    elem_hold_a: assert property (
        elem_valid && !elem_ready |=> elem_valid && $stable(elem_id) && $stable(elem_len))
        else $error("element changed before ready");
endmodule : pvq_ring_engine_checker

bind pvq_ring_engine pvq_ring_engine_checker i_chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .elem_valid(elem_valid),
    .elem_ready(elem_ready), .elem_addr(elem_addr), .elem_len(elem_len),
    .elem_wr(elem_wr), .elem_last(elem_last), .elem_id(elem_id), .used_notify(used_notify)
);

// file: dv/pvq_ring_engine_test.sv
// Self-checking testbench of the packed ring engine
`timescale 1ns/1ps
module pvq_ring_engine_test;
    import pvq_pkg::*;
    logic         clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, elem_len, done_len, q;
    logic         mem_req, mem_we, mem_ack, elem_valid, elem_ready, elem_wr, elem_last;
    logic [63:0]  mem_addr, elem_addr;
    logic [127:0] mem_wdata, mem_rdata;
    logic [15:0]  elem_id, done_id, done_count;
    logic         done_valid, done_ready, done_wrote, used_notify, chain_err, e, seen;
    int           n_errors, checked, n_notify, n_cerr;

    pvq_ring_engine #(.CMPL_DEPTH(16)) i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .elem_valid(elem_valid), .elem_ready(elem_ready), .elem_addr(elem_addr),
        .elem_len(elem_len), .elem_wr(elem_wr), .elem_last(elem_last), .elem_id(elem_id),
        .done_valid(done_valid), .done_ready(done_ready), .done_id(done_id),
        .done_len(done_len), .done_count(done_count), .done_wrote(done_wrote),
        .used_notify(used_notify), .chain_err(chain_err));
    pvq_mem_model i_mem (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (used_notify === 1'b1) n_notify <= n_notify + 1;
    always @(posedge clk_sys) if (chain_err === 1'b1) n_cerr <= n_cerr + 1;

    task print_verdict;
        $display("checked %0d, n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task check(input logic [127:0] s, input logic [127:0] x);
        checked++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : check

    task hang;
        check(1'b0, 1'b1);
        print_verdict();
    endtask : hang

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) hang();
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check({e, q}, {1'b0, x});
    endtask : rd

    // Driver offer: avail matches the driver wrap, used is its inverse
    function automatic logic [127:0] desc(logic w, logic [63:0] a, logic [31:0] l,
                                          logic [15:0] id, logic wf, logic nx);
        return {~w, 7'h00, w, 5'h00, wf, nx, id, l, a};
    endfunction : desc

    task get_elem(input logic [63:0] a, input logic [31:0] l, input logic wf, input logic lst,
                  input logic [15:0] id);
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            if (elem_valid === 1'b1) break;
        end
        if (i == 200) hang();
        elem_ready <= 1'b1;
        @(posedge clk_sys);
        check({elem_addr, elem_len, elem_wr, elem_last}, {a, l, wf, lst});
        if (lst) check(elem_id, id);
        elem_ready <= 1'b0;
    endtask : get_elem

    task send_done(input logic [15:0] id, input logic [31:0] l, input logic [15:0] c,
                   input logic w, input int n);
        int i;
        @(posedge clk_sys);
        done_valid <= 1'b1;
        done_id    <= id;
        done_len   <= l;
        done_count <= c;
        done_wrote <= w;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (done_ready === 1'b1) break;
        end
        if (i == 50) hang();
        done_valid <= 1'b0;
        for (i = 0; i < 300 && n_notify < n; i++) @(posedge clk_sys);
        if (n_notify < n) hang();
    endtask : send_done

    initial begin
        {psel, penable, pwrite, paddr, pwdata, elem_ready} = '0;
        {done_valid, done_id, done_len, done_count, done_wrote} = '0;
        n_notify = 0;
        rst = 1'b1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        // ----------------------------------------------------------
        // Registers
        // ----------------------------------------------------------
        rd(REG_SIZE, {16'h0, SIZE_RST});
        rd(REG_CHAINMAX, 32'h0);
        rd(REG_USEDCNT, 32'h0);
        rd(REG_STATUS, 32'h8000_8000);
        apb(1'b0, 12'h024, 32'h0);
        check({e, q}, {1'b1, 32'h0});
        apb(1'b1, REG_DEVSUP, 32'h0000_1234);
        apb(1'b1, REG_DRVSUP, 32'h0000_5678);
        rd(REG_DEVSUP, 32'h0000_1234);
        rd(REG_DRVSUP, 32'h0000_5678);
        apb(1'b1, REG_SIZE, 32'h0);
        rd(REG_SIZE, 32'h8000);
        $display("test registers done");
        // ----------------------------------------------------------
        // Stale wrap, chain, out-of-order completion
        // ----------------------------------------------------------
        i_mem.put(0, desc(1'b0, 64'h2000, 32'h10, 16'h5, 1'b0, 1'b0));
        apb(1'b1, REG_BASE_LO, 32'h0000_1000);
        apb(1'b1, REG_BASE_HI, 32'h0);
        apb(1'b1, REG_SIZE, 32'h4);
        apb(1'b1, REG_CTRL, 32'h1);
        seen = 1'b0;
        repeat (40) @(posedge clk_sys) if (elem_valid !== 1'b0) seen = 1'b1;
        check(seen, 1'b0);
        // Later chain entries first, head published last
        i_mem.put(2, desc(1'b1, 64'h2200, 32'h40, 16'h7, 1'b1, 1'b0));
        i_mem.put(1, desc(1'b1, 64'h2100, 32'h20, 16'h0, 1'b0, 1'b1));
        i_mem.put(0, desc(1'b1, 64'h2000, 32'h10, 16'h5, 1'b0, 1'b0));
        get_elem(64'h2000, 32'h10, 1'b0, 1'b1, 16'h5);
        get_elem(64'h2100, 32'h20, 1'b0, 1'b0, 16'h0);
        get_elem(64'h2200, 32'h40, 1'b1, 1'b1, 16'h7);
        send_done(16'h7, 32'h30, 16'h2, 1'b1, 1);
        check(i_mem.ram[0], {16'h8082, 16'h7, 32'h30, 64'h0});
        send_done(16'h5, 32'h0, 16'h1, 1'b0, 2);
        // Length is reserved without the write flag, so only flags and id
        check(i_mem.ram[2][127:96], {16'h8080, 16'h5});
        rd(REG_STATUS, 32'h8003_8003);
        rd(REG_USEDCNT, 32'h2);
        $display("test chain done");
        // ----------------------------------------------------------
        // Wrap of both counters
        // ----------------------------------------------------------
        apb(1'b1, REG_CHAINMAX, 32'h1);
        i_mem.put(3, desc(1'b1, 64'h3000, 32'h8, 16'h9, 1'b0, 1'b1));
        i_mem.put(0, desc(1'b0, 64'h3100, 32'h8, 16'ha, 1'b1, 1'b0));
        get_elem(64'h3000, 32'h8, 1'b0, 1'b1, 16'h9);
        get_elem(64'h3100, 32'h8, 1'b1, 1'b1, 16'ha);
        send_done(16'h9, 32'h0, 16'h1, 1'b0, 3);
        send_done(16'ha, 32'h4, 16'h1, 1'b1, 4);
        check(i_mem.ram[3][127:96], {16'h8080, 16'h9});
        check(i_mem.ram[0], {16'h0002, 16'ha, 32'h4, 64'h0});
        rd(REG_STATUS, 32'h0001_0001);
        check(n_notify, 4);
        check(n_cerr, 1);
        $display("test wrap done");
        print_verdict();
    end
endmodule : pvq_ring_engine_test

// file: include/pvq_pkg.sv
// Constants, descriptor layout and register map of the packed ring engine
package pvq_pkg;

    // ------------------------------------------------------------------
    // Descriptor layout, 16 bytes: addr, len, id, flags
    // ------------------------------------------------------------------
    localparam int          DESC_BYTES   = 16;
    localparam int          FLAG_NEXT    = 0;
    localparam int          FLAG_WRITE   = 1;
    localparam int          FLAG_AVAIL   = 7;
    localparam int          FLAG_USED    = 15;
    localparam int          RING_MAX     = 32768;
    localparam int          RING_IDX_W   = 15;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_BASE_LO  = 12'h004;
    localparam logic [11:0] REG_BASE_HI  = 12'h008;
    localparam logic [11:0] REG_SIZE     = 12'h00c;
    localparam logic [11:0] REG_STATUS   = 12'h010;
    localparam logic [11:0] REG_DEVSUP   = 12'h014;
    localparam logic [11:0] REG_DRVSUP   = 12'h018;
    localparam logic [11:0] REG_CHAINMAX = 12'h01c;
    localparam logic [11:0] REG_USEDCNT  = 12'h020;

    localparam int          CTRL_EN      = 0;
    localparam logic [15:0] SIZE_RST     = 16'h0100;
    localparam logic [15:0] CHAINMAX_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        PVQ_IDLE  = 7'h01,
        PVQ_POLL  = 7'h02,
        PVQ_PWAIT = 7'h04,
        PVQ_HAND  = 7'h08,
        PVQ_CWAIT = 7'h10,
        PVQ_WUSED = 7'h20,
        PVQ_UWAIT = 7'h40
    } pvq_state_t;

endpackage : pvq_pkg

// file: logic/pvq_cmpl_fifo.sv
// Completion order queue: records the order in which buffers finish
`timescale 1ns/1ps
module pvq_cmpl_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Write side
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read side
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("pvq_cmpl_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_ff;
    logic [AW:0]      rp_ff;
    logic             push;
    logic             pop;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ready <= 1'b1;
        end else begin
            wr_ready <= wp_ff + (AW+1)'(push) - rp_ff - (AW+1)'(pop) != (AW+1)'(DEPTH);
        end
    end
    assign rd_valid = wp_ff != rp_ff;
    assign rd_data  = mem[rp_ff[AW-1:0]];
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_ff[AW-1:0]] <= wr_data;
        end
    end

    // Completion order preserved: first finished, first written back
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end

endmodule : pvq_cmpl_fifo

// file: logic/pvq_ring_engine.sv
// Device-side packed descriptor ring engine with APB registers
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module pvq_ring_engine
    import pvq_pkg::*;
#(
    parameter int CMPL_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory master, one 128-bit descriptor per beat
    output logic             mem_req,
    output logic             mem_we,
    output logic      [63:0] mem_addr,
    output logic     [127:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [127:0] mem_rdata,
    // Buffer handed to the function, one element per valid/ready handshake, elem_valid held until elem_ready
    output logic             elem_valid,
    input  wire logic        elem_ready,
    output logic      [63:0] elem_addr,
    output logic      [31:0] elem_len,
    output logic             elem_wr,
    output logic             elem_last,
    output logic      [15:0] elem_id,
    // Completion from the function, any order
    input  wire logic        done_valid,
    output logic             done_ready,
    input  wire logic [15:0] done_id,
    input  wire logic [31:0] done_len,
    input  wire logic [15:0] done_count,
    input  wire logic        done_wrote,
    // Used-buffer notification and chain-length error
    output logic             used_notify,
    output logic             chain_err
);
    import pvq_pkg::*;

    initial begin
        if (CMPL_DEPTH < 2) begin
            $error("pvq_ring_engine: CMPL_DEPTH too small");
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic        en_ff;
    logic [63:0] base_ff;
    logic [15:0] size_ff;
    logic [15:0] chainmax_ff;
    logic [31:0] devsup_ff;
    logic [31:0] drvsup_ff;
    logic [31:0] usedcnt_ff;
    logic        apb_wr;
    logic        apb_rd;
    logic        addr_ok;

    pvq_state_t  st_ff;
    logic [14:0] avail_idx_ff;
    logic        avail_wrap_ff;
    logic [14:0] used_idx_ff;
    logic        used_wrap_ff;
    logic [15:0] chain_len_ff;
    logic [127:0] desc_ff;

    function automatic logic [14:0] ring_step(input logic [14:0] idx,
                                              input logic [15:0] n,
                                              input logic [15:0] sz);
        logic [16:0] s;
        s = {2'b00, idx} + {1'b0, n};
        if (s >= {1'b0, sz}) begin
            s = s - {1'b0, sz};
        end
        return s[14:0];
    endfunction : ring_step

    function automatic logic ring_wraps(input logic [14:0] idx,
                                        input logic [15:0] n,
                                        input logic [15:0] sz);
        logic [16:0] s;
        s = {2'b00, idx} + {1'b0, n};
        return s >= {1'b0, sz};
    endfunction : ring_wraps

    function automatic logic [63:0] slot_addr(input logic [63:0] b,
                                              input logic [14:0] idx);
        return b + {45'h0, idx, 4'h0};
    endfunction : slot_addr

    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && !penable && !pwrite;
    assign addr_ok = paddr[1:0] == 2'b00 && paddr <= REG_USEDCNT;

    // Ring size limited to 1..32768
    function automatic logic [15:0] clamp_size(input logic [31:0] v);
        if (v == 32'h0 || v > 32'(RING_MAX)) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction : clamp_size

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en_ff       <= 1'b0;
            base_ff     <= '0;
            size_ff     <= SIZE_RST;
            chainmax_ff <= CHAINMAX_RST;
            devsup_ff   <= '0;
        end else if (apb_wr) begin
            unique case (paddr)
                REG_CTRL:     en_ff <= pwdata[CTRL_EN];
                REG_BASE_LO:  base_ff[31:0] <= {pwdata[31:4], 4'h0};
                REG_BASE_HI:  base_ff[63:32] <= pwdata;
                REG_SIZE:     size_ff <= clamp_size(pwdata);
                REG_DEVSUP:   devsup_ff <= pwdata;
                REG_CHAINMAX: chainmax_ff <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Driver suppression is only ever loaded by software mirror, never by the engine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drvsup_ff <= '0;
        end else if (apb_wr && paddr == REG_DRVSUP) begin
            drvsup_ff <= pwdata;
        end
    end

    // Read data captured in setup; answer in one access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (apb_rd) begin
                unique case (paddr)
                    REG_CTRL:     prdata <= {31'h0, en_ff};
                    REG_BASE_LO:  prdata <= base_ff[31:0];
                    REG_BASE_HI:  prdata <= base_ff[63:32];
                    REG_SIZE:     prdata <= {16'h0, size_ff};
                    REG_STATUS:   prdata <= {used_wrap_ff, used_idx_ff,
                                             avail_wrap_ff, avail_idx_ff};
                    REG_DEVSUP:   prdata <= devsup_ff;
                    REG_DRVSUP:   prdata <= drvsup_ff;
                    REG_CHAINMAX: prdata <= {16'h0, chainmax_ff};
                    REG_USEDCNT:  prdata <= usedcnt_ff;
                    default:      prdata <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Completion queue
    // ------------------------------------------------------------------
    logic        cq_valid;
    logic        cq_pop;
    logic [64:0] cq_data;

    pvq_cmpl_fifo #(.WIDTH(65), .DEPTH(CMPL_DEPTH)) u_cq (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_valid (done_valid),
        .wr_ready (done_ready),
        .wr_data  ({done_wrote, done_count, done_len, done_id}),
        .rd_valid (cq_valid),
        .rd_ready (cq_pop),
        .rd_data  (cq_data)
    );

    // ------------------------------------------------------------------
    // Ring state machine
    // ------------------------------------------------------------------
    logic [15:0] desc_flags;
    logic        desc_is_avail;
    logic [15:0] chain_lim;
    logic [15:0] used_flags;

    assign desc_flags    = desc_ff[127:112];
    // Available only when avail flag matches and used flag differs
    assign desc_is_avail = desc_flags[FLAG_AVAIL] == avail_wrap_ff &&
                           desc_flags[FLAG_USED] != avail_wrap_ff;
    assign chain_lim     = (chainmax_ff != 16'h0 && chainmax_ff < size_ff) ?
                           chainmax_ff : size_ff;
    assign used_flags    = (16'h1 << FLAG_USED) * {15'h0, used_wrap_ff} |
                           (16'h1 << FLAG_AVAIL) * {15'h0, used_wrap_ff} |
                           (16'h1 << FLAG_WRITE) * {15'h0, cq_data[64]};
    assign cq_pop        = st_ff == PVQ_UWAIT && mem_ack;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff         <= PVQ_IDLE;
            avail_idx_ff  <= '0;
            avail_wrap_ff <= 1'b1;
            used_idx_ff   <= '0;
            used_wrap_ff  <= 1'b1;
            chain_len_ff  <= '0;
            desc_ff       <= '0;
            mem_req       <= 1'b0;
            mem_we        <= 1'b0;
            mem_addr      <= '0;
            mem_wdata     <= '0;
            elem_valid    <= 1'b0;
            elem_addr     <= '0;
            elem_len      <= '0;
            elem_wr       <= 1'b0;
            elem_last     <= 1'b0;
            elem_id       <= '0;
            used_notify   <= 1'b0;
            chain_err     <= 1'b0;
            usedcnt_ff    <= '0;
        end else begin
            used_notify <= 1'b0;
            chain_err   <= 1'b0;
            unique case (st_ff)
                PVQ_IDLE: begin
                    if (en_ff) begin
                        st_ff <= PVQ_POLL;
                    end
                end
                PVQ_POLL: begin
                    // Completions take priority so the ring keeps draining
                    if (cq_valid) begin
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= slot_addr(base_ff, used_idx_ff);
                        mem_wdata <= {used_flags, cq_data[15:0],
                                      cq_data[47:16], 64'h0};
                        st_ff     <= PVQ_UWAIT;
                    end else if (!en_ff) begin
                        st_ff <= PVQ_IDLE;
                    end else begin
                        mem_req  <= 1'b1;
                        mem_we   <= 1'b0;
                        mem_addr <= slot_addr(base_ff, avail_idx_ff);
                        st_ff    <= PVQ_PWAIT;
                    end
                end
                PVQ_PWAIT: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        desc_ff <= mem_rdata;
                        st_ff   <= PVQ_HAND;
                    end
                end
                PVQ_HAND: begin
                    if (!desc_is_avail) begin
                        st_ff <= PVQ_POLL;
                    end else begin
                        elem_valid <= 1'b1;
                        elem_addr  <= desc_ff[63:0];
                        elem_len   <= desc_ff[95:64];
                        elem_wr    <= desc_flags[FLAG_WRITE];
                        elem_last  <= !desc_flags[FLAG_NEXT]
                                      || chain_len_ff + 16'h1 >= chain_lim;
                        elem_id    <= desc_ff[111:96];
                        chain_err  <= desc_flags[FLAG_NEXT]
                                      && chain_len_ff + 16'h1 >= chain_lim;
                        st_ff      <= PVQ_CWAIT;
                    end
                end
                PVQ_CWAIT: begin
                    if (elem_ready) begin
                        elem_valid <= 1'b0;
                        // Next entry in circular order
                        avail_idx_ff <= ring_step(avail_idx_ff, 16'h1, size_ff);
                        if (ring_wraps(avail_idx_ff, 16'h1, size_ff)) begin
                            avail_wrap_ff <= !avail_wrap_ff;
                        end
                        chain_len_ff <= elem_last ? 16'h0 : chain_len_ff + 16'h1;
                        st_ff <= PVQ_POLL;
                    end
                end
                PVQ_UWAIT: begin
                    if (mem_ack) begin
                        mem_req     <= 1'b0;
                        mem_we      <= 1'b0;
                        used_notify <= 1'b1;
                        usedcnt_ff  <= usedcnt_ff + 32'h1;
                        // One used entry covers the whole chain, skip the rest
                        used_idx_ff <= ring_step(used_idx_ff, cq_data[63:48],
                                                 size_ff);
                        if (ring_wraps(used_idx_ff, cq_data[63:48], size_ff)) begin
                            used_wrap_ff <= !used_wrap_ff;
                        end
                        st_ff <= PVQ_POLL;
                    end
                end
                default: st_ff <= PVQ_IDLE;
            endcase
        end
    end

endmodule : pvq_ring_engine
